// ===== src/flash_cmd_pkg.sv
// Opcodes, register layouts, reset values and timing counts shared by both ends of the flash link.
package flash_cmd_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS   = 8'h05;
	localparam logic [7:0] OP_READ          = 8'h03;
	localparam logic [7:0] OP_FAST_READ     = 8'h0B;
	localparam logic [7:0] OP_SLEEP         = 8'hB9;
	localparam logic [7:0] OP_WAKE          = 8'hAB;
	localparam logic [7:0] OP_SET_RP_NV     = 8'h65;
	localparam logic [7:0] OP_SET_RP_V_WEL  = 8'h63;
	localparam logic [7:0] OP_SET_RP_V      = 8'hC0;
	localparam logic [7:0] OP_SET_ERP_NV    = 8'h85;
	localparam logic [7:0] OP_SET_ERP_V     = 8'h83;
	localparam logic [7:0] OP_READ_RP       = 8'h61;
	localparam logic [7:0] OP_READ_ERP      = 8'h81;
	localparam logic [7:0] OP_CLEAR_ERR     = 8'h82;
	localparam int RP_BURST_LSB   = 0;
	localparam int RP_WRAP_BIT    = 2;
	localparam int RP_DUMMY_LSB   = 3;
	localparam int RP_HOLD_RST    = 7;
	localparam int ERP_BUSY_BIT   = 0;
	localparam int ERP_PROT_BIT   = 2;
	localparam int ERP_PROG_BIT   = 3;
	localparam int ERP_ERASE_BIT  = 4;
	localparam int ERP_DRIVE_LSB  = 5;
	localparam int SR_BUSY_BIT    = 0;
	localparam int SR_WEL_BIT     = 1;
	localparam logic [7:0] RP_RESET   = 8'h00;
	// Code of the half-strength drive step; the encoding table lives outside this block.
	localparam logic [2:0] DRIVE_HALF = 3'h4;
	localparam logic [7:0] BURST_MIN  = 8'h08;
	localparam logic [1:0] PRE_BYTES  = 2'h2;
	localparam int CLK_PERIOD_NS         = 10;
	localparam int WAKE_RECOVERY_NS      = 3000;
	localparam int WAKE_RECOVERY_CYCLES  = (WAKE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_HALF_CYCLES      = 6;
	localparam int HOST_GAP_CYCLES       = 4;
	typedef enum logic [2:0] {
		S_OPC   = 3'b000,
		S_ADDR  = 3'b001,
		S_DUMMY = 3'b010,
		S_OUT   = 3'b011,
		S_DONE  = 3'b100,
		S_SKIP  = 3'b101
	} dev_state_e;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LOW  = 2'b01,
		H_HIGH = 2'b10,
		H_GAP  = 2'b11
	} host_state_e;
endpackage

// ===== src/flash_link.sv
// Serial flash link between the host controller and the device command logic.
`timescale 1ns/100ps
`default_nettype none
interface flash_link;
	logic cs_n;
	logic sck;
	logic mosi;
	logic reset_pin_n;
	logic miso;
	logic miso_oe;
	logic miso_line;
	// The data-out wire floats high through a pull-up while the device does not drive it.
	assign miso_line = miso_oe ? miso : 1'b1;
	modport dev (input cs_n, input sck, input mosi, input reset_pin_n, input miso_line, output miso, output miso_oe);
	modport host (output cs_n, output sck, output mosi, output reset_pin_n, input miso_line);
endinterface
`default_nettype wire

// ===== src/sync2.sv
// Two-flop synchroniser for a bundle of independent level signals.
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_reg <= INIT;
			q        <= INIT;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ===== src/flash_cmd_host.sv
// Host end: shifts one command frame per request out on the link and returns the read bytes.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_host #(
	parameter int HALF        = flash_cmd_pkg::HOST_HALF_CYCLES,
	parameter int GAP         = flash_cmd_pkg::HOST_GAP_CYCLES,
	parameter int WAKE_CYCLES = flash_cmd_pkg::WAKE_RECOVERY_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	flash_link.host          link,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_opcode,
	input  wire logic [2:0]  cmd_tx_count,
	input  wire logic [31:0] cmd_tx_data,
	input  wire logic [4:0]  cmd_dummy_bits,
	input  wire logic [7:0]  cmd_rx_count,
	input  wire logic        pin_reset_req,
	output logic             cmd_ready,
	output logic             rx_valid,
	output logic      [7:0]  rx_data,
	output logic             cmd_done
);
	import flash_cmd_pkg::*;
	host_state_e state_reg;
	logic [15:0] tmr_reg;
	logic [15:0] gap_reg;
	logic [39:0] tx_reg;
	logic [11:0] total_reg;
	logic [11:0] idx_reg;
	logic [11:0] rx_start_reg;
	logic [7:0]  rx_sh_reg;
	logic        cs_n_reg;
	logic        sck_reg;
	logic        mosi_reg;
	logic        rst_pin_reg;
	logic        miso_s;
	wire  [11:0] nbits     = 12'h008 + {6'h00, cmd_tx_count, 3'h0} + {7'h00, cmd_dummy_bits} + {1'b0, cmd_rx_count, 3'h0};
	wire  [11:0] rx_first  = 12'h008 + {6'h00, cmd_tx_count, 3'h0} + {7'h00, cmd_dummy_bits};
	wire  [11:0] rx_pos    = idx_reg - rx_start_reg;
	wire         half_done = tmr_reg == 16'(HALF - 1);
	wire         gap_done  = tmr_reg == gap_reg;
	wire         last_bit  = idx_reg == total_reg - 12'h001;
	wire         rx_bit    = idx_reg >= rx_start_reg;
	// A wake frame is the opcode alone; the link then stays deselected for the whole recovery time.
	wire         wake_only = cmd_opcode == OP_WAKE && cmd_tx_count == 3'h0 && cmd_rx_count == 8'h00; // [RULE1]
	wire [15:0]  gap_len   = wake_only ? 16'(WAKE_CYCLES - 1) : 16'(GAP - 1); // [RULE2]

	sync2 #(.W(1), .INIT(1'b1)) u_miso_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (link.miso_line),
		.q      (miso_s)
	);

	assign link.cs_n        = cs_n_reg;
	assign link.sck         = sck_reg;
	assign link.mosi        = mosi_reg;
	assign link.reset_pin_n = rst_pin_reg;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_pin_reg <= 1'b1;
		else
			rst_pin_reg <= ~pin_reset_req;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg    <= H_IDLE;
			tmr_reg      <= 16'h0000;
			gap_reg      <= 16'h0000;
			tx_reg       <= 40'h00_0000_0000;
			total_reg    <= 12'h000;
			idx_reg      <= 12'h000;
			rx_start_reg <= 12'h000;
			rx_sh_reg    <= 8'h00;
			cs_n_reg     <= 1'b1;
			sck_reg      <= 1'b0;
			mosi_reg     <= 1'b0;
			cmd_ready    <= 1'b1;
			rx_valid     <= 1'b0;
			rx_data      <= 8'h00;
			cmd_done     <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			cmd_done <= 1'b0;
			tmr_reg  <= tmr_reg + 16'h0001;
			case (state_reg)
				H_IDLE:
				begin
					tmr_reg <= 16'h0000;
					if (cmd_valid)
					begin
						state_reg    <= H_LOW;
						tx_reg       <= {cmd_opcode, cmd_tx_data};
						mosi_reg     <= cmd_opcode[7];
						total_reg    <= nbits;
						rx_start_reg <= rx_first;
						gap_reg      <= gap_len;
						idx_reg      <= 12'h000;
						cs_n_reg     <= 1'b0;
						cmd_ready    <= 1'b0;
					end
				end
				H_LOW:
				begin
					if (half_done)
					begin
						state_reg <= H_HIGH;
						sck_reg   <= 1'b1;
						tmr_reg   <= 16'h0000;
					end
				end
				H_HIGH:
				begin
					if (half_done)
					begin
						sck_reg <= 1'b0;
						tmr_reg <= 16'h0000;
						if (rx_bit)
						begin
							rx_sh_reg <= {rx_sh_reg[6:0], miso_s};
							if (rx_pos[2:0] == 3'h7)
							begin
								rx_valid <= 1'b1;
								rx_data  <= {rx_sh_reg[6:0], miso_s};
							end
						end
						if (last_bit)
						begin
							state_reg <= H_GAP;
							cs_n_reg  <= 1'b1;
							cmd_done  <= 1'b1;
						end
						else
						begin
							state_reg <= H_LOW;
							idx_reg   <= idx_reg + 12'h001;
							tx_reg    <= {tx_reg[38:0], 1'b0};
							mosi_reg  <= tx_reg[38];
						end
					end
				end
				H_GAP:
				begin
					if (gap_done) // [RULE2]
					begin
						state_reg <= H_IDLE;
						cmd_ready <= 1'b1;
					end
				end
				default:
					state_reg <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== src/flash_cmd_device.sv
// Device end: wake, signature, read-parameter and extended-parameter commands of a serial flash.
// Functional notes
// RULE1 - Wake opcode then deselect starts return to operation.
// RULE2 - No command taken during wake recovery time.
// RULE3 - Wake/signature ignored while an operation is busy.
// RULE4 - Read params: burst 2..0, dummy 6..3, pin select 7.
// RULE5 - Persistent read-param write needs write enable latch.
// RULE6 - Alternate-first volatile write also needs write enable.
// RULE7 - Other volatile write opcode needs no write enable.
// RULE8 - Persistent read-param write also loads volatile copy.
// RULE9 - Dedicated reset pin variant ignores pin select bit.
// RULE10 - Wrap reads cycle inside aligned window until deselect.
// RULE11 - Burst codes 0-3 linear, 4-7 wrap 8..64.
// RULE12 - Without wrap address increments across whole array.
// RULE13 - Wrap persists until volatile write, sleep or reset; sleep leaves read_params, and so wrap, unchanged here.
// RULE14 - Every read variant applies wrap when enabled.
// RULE15 - Extended register holds three-bit drive strength field.
// RULE16 - Drive strength resets to half-strength setting.
// RULE17 - Persistent extended write also loads volatile copy.
// RULE18 - Read-param readback returns only the volatile register.
// RULE19 - Extended readback works even while busy, shows busy.
// RULE20 - Error flags sticky until the clear command.
// RULE21 - Signature: three dummy bytes, then code repeated MSB first.
// RULE22 - In sleep only the wake opcode is recognised.
// RULE23 - Dummy field maps to latency via parameter table.
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_device #(
	parameter int          WAKE_CYCLES     = flash_cmd_pkg::WAKE_RECOVERY_CYCLES,
	parameter bit          DEDICATED_RESET = 1'b0,
	// Arbitrary signature value.
	parameter logic [7:0]  SIGNATURE       = 8'h5A,
	parameter logic [79:0] DUMMY_LUT       = {16{5'h08}}
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	flash_link.dev           link,
	input  wire logic        op_busy,
	input  wire logic        prot_err_set,
	input  wire logic        prog_err_set,
	input  wire logic        erase_err_set,
	input  wire logic [7:0]  read_data,
	output logic      [23:0] read_addr,
	output logic             read_active,
	output logic      [7:0]  read_params,
	output logic      [2:0]  drive_strength,
	output logic      [4:0]  dummy_latency,
	output logic             powered_down,
	output logic             write_enable_latch,
	output logic             reset_pin_is_reset,
	output logic      [2:0]  error_flags
);
	import flash_cmd_pkg::*;
	logic        cs_s;
	logic        sck_s;
	logic        mosi_s;
	logic        rpin_s;
	logic        cs_d_reg;
	logic        sck_d_reg;
	dev_state_e  state_reg;
	logic [2:0]  bitcnt_reg;
	logic [6:0]  in_sh_reg;
	logic [7:0]  op_reg;
	logic [1:0]  need_reg;
	logic [23:0] addr_reg;
	logic [4:0]  dcnt_reg;
	logic [2:0]  obits_reg;
	logic [6:0]  out_sh_reg;
	logic        wake_arm_reg;
	logic [15:0] rec_reg;
	logic [7:0]  rp_nv_reg;
	logic [2:0]  drv_nv_reg;
	logic        miso_reg;
	logic        oe_reg;

	sync2 #(.W(4), .INIT(4'h9)) u_link_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({link.cs_n, link.sck, link.mosi, link.reset_pin_n}),
		.q      ({cs_s, sck_s, mosi_s, rpin_s})
	);

	assign link.miso    = miso_reg;
	assign link.miso_oe = oe_reg;

	wire        sck_rise  = ~cs_s & sck_s & ~sck_d_reg;
	wire        sck_fall  = ~cs_s & ~sck_s & sck_d_reg;
	wire        cs_rise   = cs_s & ~cs_d_reg;
	wire        pin_rst   = ~rpin_s & (DEDICATED_RESET | read_params[RP_HOLD_RST]); // [RULE9]
	wire [7:0]  in_byte   = {in_sh_reg, mosi_s};
	wire        byte_end  = bitcnt_reg == 3'h7;
	wire        recovering = rec_reg != 16'h0000;
	wire        busy_ok   = in_byte == OP_READ_STATUS || in_byte == OP_READ_ERP; // [RULE19]
	wire        gate_pd   = powered_down & (in_byte != OP_WAKE); // [RULE22]
	wire        reject    = recovering | gate_pd | (op_busy & ~busy_ok); // [RULE2] [RULE3]
	wire        is_read   = op_reg == OP_READ || op_reg == OP_FAST_READ;
	wire        has_input = in_byte == OP_WAKE || in_byte == OP_READ || in_byte == OP_FAST_READ
	                     || in_byte == OP_SET_RP_NV || in_byte == OP_SET_RP_V_WEL || in_byte == OP_SET_RP_V
	                     || in_byte == OP_SET_ERP_NV || in_byte == OP_SET_ERP_V;
	wire        is_rdback = in_byte == OP_READ_STATUS || in_byte == OP_READ_RP || in_byte == OP_READ_ERP;
	wire [1:0]  in_need   = (in_byte == OP_WAKE || in_byte == OP_READ || in_byte == OP_FAST_READ) ? PRE_BYTES : 2'h0;
	wire        wrap_on   = read_params[RP_WRAP_BIT]; // [RULE11]
	wire [7:0]  win_mask  = (BURST_MIN << read_params[RP_BURST_LSB +: 2]) - 8'h01; // [RULE11]
	wire [23:0] addr_inc  = read_addr + 24'h000001; // [RULE12]
	wire [23:0] mask24    = {16'h0000, win_mask};
	wire [23:0] addr_next = wrap_on ? ((read_addr & ~mask24) | (addr_inc & mask24)) : addr_inc; // [RULE10] [RULE14]
	wire [7:0]  erp_view  = {drive_strength, error_flags, 1'b0, op_busy}; // [RULE15] [RULE19]
	wire [7:0]  sr_view   = {6'h00, write_enable_latch, op_busy};
	wire [7:0]  out_src   = op_reg == OP_WAKE ? SIGNATURE
	                      : op_reg == OP_READ_RP ? read_params
	                      : op_reg == OP_READ_ERP ? erp_view
	                      : op_reg == OP_READ_STATUS ? sr_view : read_data; // [RULE18] [RULE21]
	wire        commit    = cs_rise & (state_reg == S_DONE) & (bitcnt_reg == 3'h0);
	wire [7:0]  wdata     = addr_reg[7:0];
	wire [2:0]  wdrive    = wdata[ERP_DRIVE_LSB +: 3];

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_d_reg    <= 1'b1;
			sck_d_reg   <= 1'b0;
			read_active <= 1'b0;
		end
		else
		begin
			cs_d_reg    <= cs_s;
			sck_d_reg   <= sck_s;
			read_active <= state_reg == S_OUT;
		end
	end

	// Frame sequencer: bits are taken on rising link edges and driven on falling ones.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg    <= S_OPC;
			bitcnt_reg   <= 3'h0;
			in_sh_reg    <= 7'h00;
			op_reg       <= 8'h00;
			need_reg     <= 2'h0;
			addr_reg     <= 24'h000000;
			dcnt_reg     <= 5'h00;
			obits_reg    <= 3'h0;
			out_sh_reg   <= 7'h00;
			read_addr    <= 24'h000000;
			wake_arm_reg <= 1'b0;
			miso_reg     <= 1'b0;
			oe_reg       <= 1'b0;
		end
		else if (cs_s | pin_rst)
		begin
			state_reg    <= S_OPC;
			bitcnt_reg   <= 3'h0;
			obits_reg    <= 3'h0;
			wake_arm_reg <= 1'b0;
			oe_reg       <= 1'b0;
		end
		else if (sck_rise)
		begin
			bitcnt_reg <= bitcnt_reg + 3'h1;
			in_sh_reg  <= in_byte[6:0];
			case (state_reg)
				S_OPC:
				begin
					if (byte_end)
					begin
						op_reg       <= in_byte;
						need_reg     <= in_need;
						wake_arm_reg <= ~reject & (in_byte == OP_WAKE); // [RULE1] [RULE3]
						state_reg    <= reject ? S_SKIP : has_input ? S_ADDR : is_rdback ? S_OUT : S_DONE;
					end
				end
				S_ADDR:
				begin
					if (byte_end)
					begin
						addr_reg <= {addr_reg[15:0], in_byte};
						need_reg <= need_reg - 2'h1;
						if (need_reg == 2'h0)
						begin
							read_addr <= {addr_reg[15:0], in_byte};
							dcnt_reg  <= 5'h00;
							if (op_reg == OP_FAST_READ && dummy_latency != 5'h00)
								state_reg <= S_DUMMY;
							else if (op_reg == OP_WAKE || is_read)
								state_reg <= S_OUT; // [RULE21]
							else
								state_reg <= S_DONE;
						end
					end
				end
				S_DUMMY:
				begin
					dcnt_reg <= dcnt_reg + 5'h01;
					if (dcnt_reg == dummy_latency - 5'h01)
						state_reg <= S_OUT;
				end
				default:
					state_reg <= state_reg;
			endcase
		end
		else if (sck_fall && state_reg == S_OUT)
		begin
			oe_reg    <= 1'b1;
			obits_reg <= obits_reg + 3'h1;
			if (obits_reg == 3'h0)
			begin
				miso_reg   <= out_src[7];
				out_sh_reg <= out_src[6:0];
				if (is_read)
					read_addr <= addr_next; // [RULE10] [RULE12]
			end
			else
			begin
				miso_reg   <= out_sh_reg[6];
				out_sh_reg <= {out_sh_reg[5:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			powered_down <= 1'b0;
			rec_reg      <= 16'h0000;
		end
		else if (pin_rst)
		begin
			powered_down <= 1'b0;
			rec_reg      <= 16'h0000;
		end
		else if (cs_rise & wake_arm_reg & powered_down)
		begin
			powered_down <= 1'b0; // [RULE1]
			rec_reg      <= 16'(WAKE_CYCLES); // [RULE2]
		end
		else
		begin
			if (commit && op_reg == OP_SLEEP)
				powered_down <= 1'b1;
			if (recovering)
				rec_reg <= rec_reg - 16'h0001;
		end
	end

	// Volatile copies fall back to the persistent ones on a pin reset.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rp_nv_reg          <= RP_RESET;
			read_params        <= RP_RESET;
			drv_nv_reg         <= DRIVE_HALF; // [RULE16]
			drive_strength     <= DRIVE_HALF; // [RULE16]
			write_enable_latch <= 1'b0;
		end
		else if (pin_rst)
		begin
			read_params        <= rp_nv_reg; // [RULE13]
			drive_strength     <= drv_nv_reg;
			write_enable_latch <= 1'b0;
		end
		else if (commit)
		begin
			case (op_reg)
				OP_WRITE_ENABLE:  write_enable_latch <= 1'b1;
				OP_WRITE_DISABLE: write_enable_latch <= 1'b0;
				OP_SET_RP_NV:
				begin
					if (write_enable_latch) // [RULE5]
					begin
						rp_nv_reg   <= wdata; // [RULE4]
						read_params <= wdata; // [RULE8]
					end
					write_enable_latch <= 1'b0;
				end
				OP_SET_RP_V_WEL:
				begin
					if (write_enable_latch) // [RULE6]
						read_params <= wdata; // [RULE13]
					write_enable_latch <= 1'b0;
				end
				OP_SET_RP_V: read_params <= wdata; // [RULE7] [RULE13]
				OP_SET_ERP_NV:
				begin
					if (write_enable_latch)
					begin
						drv_nv_reg     <= wdrive; // [RULE15]
						drive_strength <= wdrive; // [RULE17]
					end
					write_enable_latch <= 1'b0;
				end
				OP_SET_ERP_V: drive_strength <= wdrive; // [RULE15]
				default: write_enable_latch <= write_enable_latch;
			endcase
		end
	end

	// A flag raised in the same cycle as the clear command survives it.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			error_flags <= 3'h0;
		else
		begin
			if (commit && op_reg == OP_CLEAR_ERR)
				error_flags <= {erase_err_set, prog_err_set, prot_err_set}; // [RULE20]
			else
				error_flags <= error_flags | {erase_err_set, prog_err_set, prot_err_set}; // [RULE20]
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dummy_latency      <= 5'h00;
			reset_pin_is_reset <= DEDICATED_RESET;
		end
		else
		begin
			dummy_latency      <= DUMMY_LUT[read_params[RP_DUMMY_LSB +: 4] * 5 +: 5]; // [RULE23]
			reset_pin_is_reset <= DEDICATED_RESET | read_params[RP_HOLD_RST]; // [RULE9]
		end
	end
endmodule
`default_nettype wire

// ===== dv/flash_link_checker.sv
// Protocol checks on the flash link wires between the host and device ends.
`timescale 1ns/100ps
`default_nettype none
module flash_link_checker
	import flash_cmd_pkg::*;
#(
	parameter int WAKE_CYCLES = 20
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	logic        sck_reg;
	logic        wake_reg;
	logic        asleep_reg;
	logic [7:0]  op_reg;
	logic [11:0] bits_reg;
	logic [15:0] high_reg;
	wire         sck_rise  = sck && !sck_reg;
	wire         frame_end = cs_n && (bits_reg != 12'h000);
	wire         op_only   = frame_end && (bits_reg == 12'h008);
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			sck_reg    <= 1'b0;
			wake_reg   <= 1'b0;
			asleep_reg <= 1'b0;
			op_reg     <= 8'h00;
			bits_reg   <= 12'h000;
			// Starts saturated so the first frame after reset never looks like an early one.
			high_reg   <= 16'hFFFF;
		end
		else
		begin
			sck_reg    <= sck;
			bits_reg   <= cs_n ? 12'h000 : bits_reg + {11'h000, sck_rise};
			op_reg     <= (sck_rise && bits_reg < 12'h008) ? {op_reg[6:0], mosi} : op_reg;
			high_reg   <= !cs_n ? 16'h0000 : high_reg + {15'h0000, high_reg != 16'hFFFF};
			wake_reg   <= frame_end ? (op_only && op_reg == OP_WAKE) : wake_reg;
			asleep_reg <= op_only ? (op_reg == OP_SLEEP || (asleep_reg && op_reg != OP_WAKE)) : asleep_reg;
		end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence lead_in;
		!sck [*6] ##1 sck;
	endsequence
	sequence high_half;
		sck [*6] ##1 (!sck || cs_n);
	endsequence
	a_frame_lead: assert property ($fell(cs_n) |-> lead_in)
		else $error("link clock started too early in frame");
	a_byte_frames: assert property (frame_end |-> bits_reg[2:0] == 3'h0)
		else $error("frame ended on a partial byte");
	a_sck_idle: assert property (cs_n && $past(cs_n) |-> !sck)
		else $error("link clock high while deselected");
	a_sck_high: assert property ($rose(sck) |-> high_half)
		else $error("link clock high phase has wrong length");
	a_wake_gap: assert property ($fell(cs_n) && wake_reg |-> high_reg >= WAKE_CYCLES - 1)
		else $error("select came back too soon after wake");
	a_sleep_silent: assert property (asleep_reg |-> !miso_oe)
		else $error("device drove data while powered down");
	a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
		else $error("data driver not released after deselect");
	a_idle_quiet: assert property (cs_n && $past(cs_n, 6) |-> !miso_oe)
		else $error("data driven while deselected");
	a_miso_hold: assert property (sck && $past(sck) && miso_oe |-> $stable(miso))
		else $error("data changed while link clock high");
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench joining the host end and the device end over the flash link.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import flash_cmd_pkg::*;
	localparam int         WK  = 20;
	// The device recovers for longer than the host waits, so an early command is seen refused.
	localparam int         WK_DEV = 150;
	// Arbitrary signature value.
	localparam logic [7:0] SIG = 8'h5A;
	typedef struct packed {logic [7:0] op; logic [2:0] n; logic [7:0] d; logic [7:0] rx; logic [7:0] exp;} row_s;
	logic        clk            = 1'b0;
	logic        arst_n         = 1'b0;
	logic        cmd_valid      = 1'b0;
	logic [7:0]  cmd_opcode     = 8'h00;
	logic [2:0]  cmd_tx_count   = 3'h0;
	logic [31:0] cmd_tx_data    = 32'h0;
	logic [4:0]  cmd_dummy_bits = 5'h00;
	logic [7:0]  cmd_rx_count   = 8'h00;
	logic        pin_reset_req  = 1'b0;
	logic        op_busy        = 1'b0;
	logic [2:0]  err_set        = 3'h0;
	logic [7:0]  read_data      = 8'h00;
	logic        cmd_ready;
	logic        rx_valid;
	logic        cmd_done;
	logic        powered_down;
	logic        write_enable_latch;
	logic        reset_pin_is_reset;
	logic        read_active;
	logic        act_seen;
	logic [7:0]  rx_data;
	logic [7:0]  read_params;
	logic [23:0] read_addr;
	logic [2:0]  drive_strength;
	logic [2:0]  error_flags;
	logic [4:0]  dummy_latency;
	logic [7:0]  m;
	logic [7:0]  q[$];
	int          n_fail = 0;
	int          comparisons = 0;
	row_s rows [21] = '{
		'{OP_READ_RP, 3'h0, 8'h00, 8'h01, RP_RESET},
		'{OP_READ_ERP, 3'h0, 8'h00, 8'h02, {DRIVE_HALF, 5'h00}},
		'{OP_SET_RP_V, 3'h1, 8'h04, 8'h00, 8'h00},
		'{OP_READ_RP, 3'h0, 8'h00, 8'h01, 8'h04},
		'{OP_READ_STATUS, 3'h0, 8'h00, 8'h01, 8'h00},
		'{OP_SET_RP_NV, 3'h1, 8'h05, 8'h00, 8'h00},
		'{OP_READ_RP, 3'h0, 8'h00, 8'h01, 8'h04},
		'{OP_SET_RP_V_WEL, 3'h1, 8'h06, 8'h00, 8'h00},
		'{OP_READ_RP, 3'h0, 8'h00, 8'h01, 8'h04},
		'{OP_WRITE_ENABLE, 3'h0, 8'h00, 8'h00, 8'h00},
		'{OP_SET_RP_NV, 3'h1, 8'h05, 8'h00, 8'h00},
		'{OP_READ_RP, 3'h0, 8'h00, 8'h01, 8'h05},
		'{OP_WRITE_ENABLE, 3'h0, 8'h00, 8'h00, 8'h00},
		'{OP_SET_RP_V_WEL, 3'h1, 8'h06, 8'h00, 8'h00},
		'{OP_READ_RP, 3'h0, 8'h00, 8'h01, 8'h06},
		'{OP_SET_ERP_V, 3'h1, 8'h20, 8'h00, 8'h00},
		'{OP_READ_ERP, 3'h0, 8'h00, 8'h01, 8'h20},
		'{OP_WRITE_ENABLE, 3'h0, 8'h00, 8'h00, 8'h00},
		'{OP_SET_ERP_NV, 3'h1, 8'h60, 8'h00, 8'h00},
		'{OP_READ_ERP, 3'h0, 8'h00, 8'h01, 8'h60},
		'{OP_WAKE, 3'h3, 8'h00, 8'h02, SIG}
	};
	flash_link flash_link_i ();
	flash_cmd_host #(.WAKE_CYCLES(WK)) flash_cmd_host_i (.clk(clk), .arst_n(arst_n), .link(flash_link_i),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_tx_count(cmd_tx_count), .cmd_tx_data(cmd_tx_data),
		.cmd_dummy_bits(cmd_dummy_bits), .cmd_rx_count(cmd_rx_count), .pin_reset_req(pin_reset_req),
		.cmd_ready(cmd_ready), .rx_valid(rx_valid), .rx_data(rx_data), .cmd_done(cmd_done));
	flash_cmd_device #(.WAKE_CYCLES(WK_DEV), .SIGNATURE(SIG)) flash_cmd_device_i (.clk(clk), .arst_n(arst_n),
		.link(flash_link_i), .op_busy(op_busy), .prot_err_set(err_set[0]), .prog_err_set(err_set[1]),
		.erase_err_set(err_set[2]), .read_data(read_data), .read_addr(read_addr), .read_active(read_active),
		.read_params(read_params), .drive_strength(drive_strength), .dummy_latency(dummy_latency),
		.powered_down(powered_down), .write_enable_latch(write_enable_latch),
		.reset_pin_is_reset(reset_pin_is_reset), .error_flags(error_flags));
	flash_link_checker #(.WAKE_CYCLES(WK)) flash_link_checker_i (.clk(clk), .arst_n(arst_n),
		.cs_n(flash_link_i.cs_n), .sck(flash_link_i.sck), .mosi(flash_link_i.mosi), .miso(flash_link_i.miso),
		.miso_oe(flash_link_i.miso_oe));
	always #5 clk = ~clk;
	// The array stand-in returns the low address byte, so every read byte names its own address.
	always @(negedge clk) read_data <= read_addr[7:0];
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		if (got !== exp)
			n_fail++;
	endtask
	task automatic end_sim;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] op, input logic [2:0] n, input logic [31:0] d, input logic [4:0] dm,
		input logic [7:0] rx);
		int t;
		t = 0;
		q = {};
		act_seen = 1'b0;
		while (cmd_ready !== 1'b1 && t < 5000)
		begin
			@(negedge clk);
			t++;
		end
		cmd_opcode = op;
		cmd_tx_count = n;
		cmd_tx_data = d;
		cmd_dummy_bits = dm;
		cmd_rx_count = rx;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (cmd_done !== 1'b1 && t < 5000)
		begin
			@(negedge clk);
			t++;
			if (rx_valid === 1'b1)
				q.push_back(rx_data);
			if (read_active === 1'b1)
				act_seen = 1'b1;
		end
		// Lets the device act on the deselect before the caller looks at its outputs.
		repeat (6) @(negedge clk);
		if (t >= 5000)
			chk(8'h00, 8'hFF);
	endtask
	initial
	begin
		#600000;
		n_fail++;
		end_sim();
	end
	initial
	begin
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		chk(read_params, RP_RESET);
		chk({5'h00, drive_strength}, {5'h00, DRIVE_HALF});
		chk({7'h00, write_enable_latch}, 8'h00);
		@(negedge clk);
		chk({3'h0, dummy_latency}, 8'h08);
		$display("reset test done");
		foreach (rows[i])
		begin
			xfer(rows[i].op, rows[i].n, {rows[i].d, 24'h0}, 5'h00, rows[i].rx);
			chk(8'(q.size()), rows[i].rx);
			foreach (q[j])
				chk(q[j], rows[i].exp);
		end
		$display("row test done");
		for (int c = 3; c < 8; c++)
			for (int k = 0; k < 2; k++)
			begin
				xfer(OP_SET_RP_V, 3'h1, {8'(c), 24'h0}, 5'h00, 8'h00);
				xfer(k ? OP_FAST_READ : OP_READ, 3'h3, 32'h0000FE00, k ? 5'h08 : 5'h00, 8'h0A);
				m = (c < 4) ? 8'hFF : 8'((8 << (c - 4)) - 1);
				for (int i = 0; i < 10; i++)
					chk(q[i], ((8'hFE + 8'(i)) & m) | (8'hFE & ~m));
				chk({7'h00, act_seen}, 8'h01);
			end
		$display("burst test done");
		op_busy = 1'b1;
		xfer(OP_READ_ERP, 3'h0, 32'h0, 5'h00, 8'h01);
		chk(q[0], 8'h61);
		xfer(OP_WAKE, 3'h3, 32'h0, 5'h00, 8'h01);
		chk(q[0], 8'hFF);
		op_busy = 1'b0;
		err_set = 3'h7;
		@(negedge clk);
		err_set = 3'h0;
		xfer(OP_READ_ERP, 3'h0, 32'h0, 5'h00, 8'h01);
		chk(q[0], 8'h7C);
		xfer(OP_CLEAR_ERR, 3'h0, 32'h0, 5'h00, 8'h00);
		chk({5'h00, error_flags}, 8'h00);
		$display("busy and error test done");
		// A pulse on the shared pin must be ignored while it is set to hold.
		for (int p = 0; p < 2; p++)
		begin
			if (p)
				xfer(OP_SET_RP_V, 3'h1, 32'h84000000, 5'h00, 8'h00);
			chk({7'h00, reset_pin_is_reset}, 8'(p));
			pin_reset_req = 1'b1;
			repeat (10) @(negedge clk);
			pin_reset_req = 1'b0;
			repeat (10) @(negedge clk);
			chk(read_params, p ? 8'h05 : 8'h07);
		end
		chk({5'h00, drive_strength}, 8'h03);
		$display("pin reset test done");
		xfer(OP_SLEEP, 3'h0, 32'h0, 5'h00, 8'h00);
		chk({7'h00, powered_down}, 8'h01);
		xfer(OP_READ_STATUS, 3'h0, 32'h0, 5'h00, 8'h01);
		chk(q[0], 8'hFF);
		xfer(OP_WAKE, 3'h0, 32'h0, 5'h00, 8'h00);
		chk({7'h00, powered_down}, 8'h00);
		xfer(OP_READ_STATUS, 3'h0, 32'h0, 5'h00, 8'h01);
		chk(q[0], 8'hFF);
		xfer(OP_READ_STATUS, 3'h0, 32'h0, 5'h00, 8'h01);
		chk(q[0], 8'h00);
		$display("wake test done");
		end_sim();
	end
endmodule
`default_nettype wire
